// >>> common/swl_cfg.svh
`ifndef SWL_CFG_SVH
`define SWL_CFG_SVH

// shift register and frame counter geometry
`define SWL_WORD_W 16
`define SWL_CNT_W 5
`define SWL_WORD_BITS 5'h10

// reset values
`define SWL_SR_RST 16'h0000
`define SWL_CNT_RST 5'h00
`define SWL_SOUT_RST 1'b0
`define SWL_STROBE_IDLE 1'b1

// serial clock limit, host side
`define SWL_SCLK_MAX_MHZ 10
`define SWL_CLK_MHZ 40
`define SWL_SCLK_MIN_CYC \
    ((`SWL_CLK_MHZ + `SWL_SCLK_MAX_MHZ - 1) / `SWL_SCLK_MAX_MHZ)

`endif

// >>> common/swl_pkg.sv
`include "swl_cfg.svh"

package swl_pkg;

    typedef logic [`SWL_WORD_W-1:0] swl_word_t;
    typedef logic [`SWL_CNT_W-1:0] swl_cnt_t;

    // captured command toward the register decode logic
    typedef struct packed {
        swl_word_t word;
        logic short_frame;
    } swl_cmd_s;

    // gray along idle -> frame -> latch
    typedef enum logic [1:0] {
        SWL_ST_IDLE = 2'b00,
        SWL_ST_FRAME = 2'b01,
        SWL_ST_LATCH = 2'b11
    } swl_state_e;

endpackage

// >>> design/swl_sync.sv
`timescale 1ns/1ps

module swl_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_async,
    output logic o_level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // =========================================================
    // three-stage chain
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // =========================================================
    // accept a change once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            level_r <= RST_VAL;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign o_level = level_r;

endmodule

// >>> design/swl_top.sv
`timescale 1ns/1ps
`include "swl_cfg.svh"

// Functional notes
// - each rising serial clock edge with the strobe low shifts the input pin into 16-bit register.
// - shifting happens only while the load strobe is low.
// - strobe rising edge captures the last sixteen shifted bits as a word.
// - serial output repeats each input bit sixteen shifting serial clocks later.
// - serial output is always driven, never floating.

module swl_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_load_strobe,
    output logic o_serial_out,
    output swl_pkg::swl_cmd_s o_cmd,
    output logic o_cmd_valid
);
    import swl_pkg::*;

    // =========================================================
    // link domain signals
    swl_word_t sr_r;
    swl_word_t sr_nxt;
    swl_cnt_t cnt_r;
    swl_cnt_t cnt_nxt;
    logic strobe_seen_r;
    logic sout_r;
    logic shift_en;

    // =========================================================
    // core domain signals
    logic strobe_lvl;
    swl_state_e state_r;
    swl_state_e state_nxt;
    swl_cmd_s cmd_r;
    logic valid_r;

    // saturating increment of the frame bit counter
    function automatic swl_cnt_t sat_inc(input swl_cnt_t c);
        swl_cnt_t r;
        r = c;
        if (c < `SWL_WORD_BITS) begin
            r = c + swl_cnt_t'(1);
        end
        return r;
    endfunction

    // =========================================================
    // link domain: shift register on serial clock
    // strobe is set up to the serial clock by the host, so it is
    // used directly here as the shift qualifier
    assign shift_en = !i_load_strobe;

    always_comb begin
        sr_nxt = sr_r;
        if (shift_en) begin
            sr_nxt = {sr_r[`SWL_WORD_W-2:0], i_serial_in};
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sr_r <= `SWL_SR_RST;
        end else begin
            sr_r <= sr_nxt;
        end
    end

    // =========================================================
    // link domain: serial output, oldest bit of the register
    // shifts only on serial clock edges with strobe low, so the delay is exactly 16 shifts
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sout_r <= `SWL_SOUT_RST;
        end else if (shift_en) begin
            sout_r <= sr_r[`SWL_WORD_W-1];
        end
    end

    // plain push-pull output, driven from reset onward
    assign o_serial_out = sout_r;

    // =========================================================
    // link domain: bits shifted in the current frame
    // first shift after strobe was high restarts the count
    always_comb begin
        cnt_nxt = cnt_r;
        if (shift_en) begin
            if (strobe_seen_r) begin
                cnt_nxt = swl_cnt_t'(1);
            end else begin
                cnt_nxt = sat_inc(cnt_r);
            end
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= `SWL_CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // serial clock may stand still between frames, so the strobe
    // itself arms the count restart for the next frame
    always_ff @(posedge i_sclk or negedge i_rst_b
            or posedge i_load_strobe) begin
        if (!i_rst_b) begin
            strobe_seen_r <= `SWL_STROBE_IDLE;
        end else if (i_load_strobe) begin
            strobe_seen_r <= 1'h1;
        end else begin
            strobe_seen_r <= 1'h0;
        end
    end

    // =========================================================
    // core domain: strobe synchroniser
    swl_sync #(
        .RST_VAL(`SWL_STROBE_IDLE)
    ) u_strobe_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_load_strobe),
        .o_level(strobe_lvl)
    );

    // =========================================================
    // core domain: frame tracking
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SWL_ST_IDLE: begin
                if (!strobe_lvl) begin
                    state_nxt = SWL_ST_FRAME;
                end
            end
            SWL_ST_FRAME: begin
                if (strobe_lvl) begin
                    state_nxt = SWL_ST_LATCH;
                end
            end
            SWL_ST_LATCH: begin
                if (strobe_lvl) begin
                    state_nxt = SWL_ST_IDLE;
                end else begin
                    state_nxt = SWL_ST_FRAME;
                end
            end
            default: begin
                state_nxt = SWL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= SWL_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =========================================================
    // core domain: word capture
    // link registers are frozen while the strobe is high, so
    // sampling them on the synchronised rising edge is safe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_r <= '0;
        end else if (state_r == SWL_ST_FRAME && strobe_lvl) begin
            cmd_r.word <= sr_r;
            cmd_r.short_frame <= (cnt_r < `SWL_WORD_BITS);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= (state_r == SWL_ST_FRAME) && strobe_lvl;
        end
    end

    assign o_cmd = cmd_r;
    assign o_cmd_valid = valid_r;

endmodule

// >>> sim/swl_host_model.sv
`timescale 1ns/1ps

module swl_host_model (
    output logic o_sclk,
    output logic o_serial_in,
    output logic o_load_strobe
);
    initial begin
        o_sclk = 1'b0;
        o_serial_in = 1'b0;
        o_load_strobe = 1'b1;
    end
    // ==========================================
    // frame: msb first, clock still outside it
    task automatic send(input logic [31:0] d, input int n, input int hp);
        o_load_strobe = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_serial_in = d[i];
            #hp o_sclk = 1'b1;
            #hp o_sclk = 1'b0;
        end
        o_serial_in = ~o_serial_in;
        #hp o_load_strobe = 1'b1;
    endtask
    // clock edges with strobe high
    task automatic idle_edges(input int n);
        repeat (n) begin
            o_serial_in = ~o_serial_in;
            #6 o_sclk = 1'b1;
            #6 o_sclk = 1'b0;
        end
    endtask
endmodule

// >>> sim/swl_top_assertions.sv
`timescale 1ns/1ps

module swl_top_checker (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_load_strobe,
    input wire logic o_serial_out,
    input swl_pkg::swl_cmd_s o_cmd,
    input wire logic o_cmd_valid
);
    import swl_pkg::*;
    swl_word_t hist_r;
    // ==========================================
    // shadow of the last sixteen shifted bits
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hist_r <= 16'h0000;
        end else if (!i_load_strobe) begin
            hist_r <= {hist_r[14:0], i_serial_in};
        end
    end
    sequence s_pulse;
        o_cmd_valid ##1 !o_cmd_valid;
    endsequence
    a_out_delay: assert property (
        @(posedge i_sclk) disable iff (!i_rst_b)
        !i_load_strobe |=> o_serial_out == $past(hist_r[15]))
        else $error("serial out delay wrong");
    a_hold_high: assert property (
        @(posedge i_sclk) disable iff (!i_rst_b)
        i_load_strobe |=> $stable(o_serial_out))
        else $error("serial out moved with strobe high");
    a_cmd_word: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_cmd_valid |-> o_cmd.word == hist_r)
        else $error("captured word wrong");
    a_cmd_answer: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(i_load_strobe) |-> ##[1:6] o_cmd_valid)
        else $error("no capture after strobe rise");
    a_one_pulse: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_cmd_valid) |-> s_pulse)
        else $error("valid pulse not single");
    a_valid_cause: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_cmd_valid) |-> i_load_strobe)
        else $error("valid while strobe low");
endmodule

// >>> sim/tb_swl_top.sv
`timescale 1ns/1ps

module tb_swl_top;
    import swl_pkg::*;
    logic i_clk, i_rst_b, i_sclk, i_serial_in, i_load_strobe;
    logic o_serial_out, o_cmd_valid;
    swl_cmd_s o_cmd;
    int failures = 0;
    int check_count = 0;
    swl_host_model i_swl_host_model (.o_sclk(i_sclk),
        .o_serial_in(i_serial_in), .o_load_strobe(i_load_strobe));
    swl_top i_swl_top (.i_clk, .i_rst_b, .i_sclk, .i_serial_in,
        .i_load_strobe, .o_serial_out, .o_cmd, .o_cmd_valid);
    // ==========================================
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [16:0] exp, logic [16:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wait_cmd(string nm, logic [16:0] exp);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(negedge i_clk);
            if (o_cmd_valid === 1'b1) begin
                seen = 1'b1;
                chk("cmd", exp, o_cmd);
            end
        end
        chk("valid", 17'h1, {16'h0, seen});
        $display("test %s done", nm);
    endtask
    // ==========================================
    task automatic t_full;
        i_swl_host_model.send(32'ha5c3, 16, 6);
        wait_cmd("full", {16'ha5c3, 1'b0});
    endtask
    task automatic t_long;
        i_swl_host_model.send(32'h1b3c9, 20, 6);
        chk("sout", 17'h1, {16'h0, o_serial_out});
        wait_cmd("long", {16'hb3c9, 1'b0});
    endtask
    task automatic t_short;
        i_swl_host_model.send(32'h5a, 8, 6);
        wait_cmd("short", {16'hc95a, 1'b1});
    endtask
    task automatic t_idle;
        i_swl_host_model.idle_edges(4);
        i_swl_host_model.send(32'h3c, 8, 50);
        wait_cmd("idle", {16'h5a3c, 1'b1});
    endtask
    // ==========================================
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        i_rst_b = 1'b0;
        repeat (16) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
        t_full();
        t_long();
        t_short();
        t_idle();
        print_verdict();
    end
    initial begin
        #50us;
        failures++;
        print_verdict();
    end
endmodule

bind swl_top swl_top_checker i_swl_top_checker (.i_clk, .i_rst_b,
    .i_sclk, .i_serial_in, .i_load_strobe, .o_serial_out, .o_cmd,
    .o_cmd_valid);
